// File: logic/nvm_pkg.sv
// constants, register map and types for the nonvolatile memory controller
package nvm_pkg;
	// ----------------------------------------------------------------
	// clock and self-timed operation lengths
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ        = 10;     // system clock rate
	localparam int unsigned PFM_ERASE_US   = 2000;   // row erase time
	localparam int unsigned PFM_WRITE_US   = 2000;   // row program time
	localparam int unsigned DFM_WRITE_US   = 4000;   // byte erase plus write
	localparam int unsigned PFM_ERASE_CYC  = PFM_ERASE_US * CLK_MHZ;
	localparam int unsigned PFM_WRITE_CYC  = PFM_WRITE_US * CLK_MHZ;
	localparam int unsigned DFM_WRITE_CYC  = DFM_WRITE_US * CLK_MHZ;
	localparam int unsigned UNLOCK_GAP_CYC = 4;      // most cycles between steps
	localparam int unsigned TIMER_W        = 20;     // operation timer width
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] OFF_ADR_LO = 16'h1c8c;   // address low byte
	localparam logic [15:0] OFF_ADR_HI = 16'h1c8d;   // address high byte
	localparam logic [15:0] OFF_DAT_LO = 16'h1c8e;   // low data register
	localparam logic [15:0] OFF_DAT_HI = 16'h1c8f;   // data high byte
	localparam logic [15:0] OFF_CTRL   = 16'h1c90;   // control register
	localparam logic [15:0] OFF_UNLOCK = 16'h1c91;   // unlock register
	localparam logic [15:0] OFF_STAT   = 16'h1c92;   // completion status
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned B_RD    = 0;             // read start
	localparam int unsigned B_WR    = 1;             // write start
	localparam int unsigned B_WRITE_ENABLE_BIT  = 2;             // write enable bit
	localparam int unsigned B_WERR  = 3;             // write error flag
	localparam int unsigned B_FREE  = 4;             // erase select
	localparam int unsigned B_LATCH_ONLY_MODE  = 5;             // latch only mode
	localparam int unsigned B_REGS  = 6;             // region select bit
	localparam int unsigned B_DONE  = 0;             // completion flag
	localparam int unsigned B_IE    = 1;             // completion interrupt enable
	// ----------------------------------------------------------------
	// values and memory map
	// ----------------------------------------------------------------
	localparam logic [7:0]  UNLOCK_A    = 8'h55;     // first unlock byte
	localparam logic [7:0]  UNLOCK_B    = 8'haa;     // second unlock byte
	localparam logic [13:0] LATCH_BLANK = 14'h3fff;  // erased latch value
	localparam int unsigned ROW_WORDS   = 32;        // latches per row
	localparam int unsigned LAT_W       = 5;         // latch index width
	localparam logic [15:0] DFM_BASE    = 16'hf000;  // data flash start
	localparam logic [15:0] DFM_SIZE    = 16'h0100;  // data flash bytes
	localparam logic [3:0]  DFM_SPACE   = 4'hf;      // data flash space nibble
	localparam logic [3:0]  IND_DFM_TAG = 4'h7;      // indirect data flash tag
	localparam logic [15:0] UID_LO      = 16'h8000;  // user id range
	localparam logic [15:0] UID_HI      = 16'h8003;
	localparam logic [15:0] CFG_LO      = 16'h8007;  // configuration word range
	localparam logic [15:0] CFG_HI      = 16'h800b;
	// array operation codes
	localparam logic [1:0]  OP_NONE  = 2'h0;
	localparam logic [1:0]  OP_ERASE = 2'h1;
	localparam logic [1:0]  OP_ROW   = 2'h2;
	localparam logic [1:0]  OP_DFM   = 2'h3;
	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ULK_IDLE, ULK_GOT_A, ULK_ARMED} unlock_e;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_STREAM, ST_PROG} ctl_e;
endpackage : nvm_pkg

// File: logic/nvm_self_write_controller.sv
// nonvolatile memory self-write controller: registers, unlock, array sequencing
`timescale 1ns/1ns
module nvm_self_write_controller #(
	parameter int unsigned PFM_ERASE_CYC  = nvm_pkg::PFM_ERASE_CYC,
	parameter int unsigned PFM_WRITE_CYC  = nvm_pkg::PFM_WRITE_CYC,
	parameter int unsigned DFM_WRITE_CYC  = nvm_pkg::DFM_WRITE_CYC,
	parameter int unsigned UNLOCK_GAP_CYC = nvm_pkg::UNLOCK_GAP_CYC
) (
	// clock and resets
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_por_n,
	// register port
	input  wire logic [15:0] i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	// cpu side
	input  wire logic        i_seq_break,
	output logic             o_cpu_stall,
	output logic             o_nvm_irq,
	// indirect read path
	input  wire logic        i_ind_rd,
	input  wire logic [15:0] i_ind_addr,
	output logic      [7:0]  o_ind_rdata,
	output logic             o_ind_valid,
	// protection configuration
	input  wire logic [14:0] i_pfm_wp_limit,
	input  wire logic        i_data_flash_protect_cfg,
	// flash array
	output logic      [15:0] o_mem_addr,
	output logic             o_mem_rd,
	input  wire logic [13:0] i_mem_rdata,
	output logic             o_mem_lat_we,
	output logic      [13:0] o_mem_wdata,
	output logic             o_mem_start,
	output logic      [1:0]  o_mem_op
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	nvm_pkg::unlock_e                ulk_q;          // unlock tracker
	nvm_pkg::ctl_e                   st_q;           // operation sequencer
	logic [3:0]                      ulk_cnt_q;      // cycles since last step
	logic [nvm_pkg::TIMER_W-1:0]     timer_q;        // self-timed countdown
	logic [nvm_pkg::LAT_W-1:0]       idx_q;          // latch stream index
	logic [7:0]                      adr_lo_q;       // address low byte
	logic [6:0]                      adr_hi_q;       // address high bits
	logic [7:0]                      dat_lo_q;       // low data register
	logic [5:0]                      dat_hi_q;       // data high bits
	logic                            regs_q;         // region select bit
	logic                            latch_only_mode_q;         // latch only mode
	logic                            free_q;         // erase select
	logic                            write_enable_bit_q;         // write enable bit
	logic                            werr_q;         // write error flag
	logic                            wr_q;           // write start bit
	logic                            rd_q;           // read start bit
	logic                            done_q;         // completion flag
	logic                            ie_q;           // completion interrupt enable
	logic                            ind_pend_q;     // indirect read in flight
	logic                            ind_dfm_q;      // indirect hit data flash
	logic [13:0]                     lat_q [nvm_pkg::ROW_WORDS];  // write latches

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [15:0] full_adr;      // region bit joined to address
	logic        wr_ctrl;       // write to control register
	logic        wr_ulk;        // write to unlock register
	logic        go;            // armed start request
	logic        g_regs;        // region bit of the start write
	logic        g_dfm_space;   // start targets data flash space
	logic        dfm_hit;       // address inside implemented data flash
	logic        pfm_wp;        // program side location is protected
	logic        reject;        // start refused for protection
	logic        ulk_broken;    // sequence interrupted
	logic        lat_load;      // latch only load
	logic        blank_lat;     // latches back to blank
	logic        op_end;        // self-timed operation finished
	logic        ind_go;        // indirect read accepted

	assign full_adr = {regs_q, adr_hi_q, adr_lo_q};
	assign wr_ctrl  = i_reg_wr && (i_reg_addr == nvm_pkg::OFF_CTRL);
	assign wr_ulk   = i_reg_wr && (i_reg_addr == nvm_pkg::OFF_UNLOCK);
	// start is only seen once the tracker is armed
	assign go       = wr_ctrl && i_reg_wdata[nvm_pkg::B_WR] &&
	                  (ulk_q == nvm_pkg::ULK_ARMED) && (st_q == nvm_pkg::ST_IDLE);
	assign g_regs   = i_reg_wdata[nvm_pkg::B_REGS];
	// region select with the space nibble routes to data flash space, else to configuration or program flash
	assign g_dfm_space = g_regs && (adr_hi_q[6:4] == nvm_pkg::DFM_SPACE[2:0]);
	assign dfm_hit  = ({1'b1, adr_hi_q, adr_lo_q} >= nvm_pkg::DFM_BASE) &&
	                  ({1'b1, adr_hi_q, adr_lo_q} < (nvm_pkg::DFM_BASE + nvm_pkg::DFM_SIZE));
	// configuration side: only user id and config words take writes
	always_comb begin
		logic [15:0] a;
		a = {g_regs, adr_hi_q, adr_lo_q};
		if (g_regs) begin
			pfm_wp = !(((a >= nvm_pkg::UID_LO) && (a <= nvm_pkg::UID_HI)) ||
			           ((a >= nvm_pkg::CFG_LO) && (a <= nvm_pkg::CFG_HI)));
		end else begin
			pfm_wp = ({adr_hi_q, adr_lo_q} < i_pfm_wp_limit);
		end
	end
	// refusal cases: protected row op, blocked or missing data flash
	always_comb begin
		reject   = 1'b0;
		lat_load = 1'b0;
		if (go && i_reg_wdata[nvm_pkg::B_WRITE_ENABLE_BIT]) begin
			if (g_dfm_space) begin
				reject = !dfm_hit || !i_data_flash_protect_cfg;
			end else if (i_reg_wdata[nvm_pkg::B_FREE]) begin
				reject = pfm_wp;
			end else if (i_reg_wdata[nvm_pkg::B_LATCH_ONLY_MODE]) begin
				lat_load = 1'b1;  // protection ignored
			end else begin
				reject = pfm_wp;
			end
		end
	end
	// a foreign write, a disturbance or a late step breaks the sequence
	assign ulk_broken = (ulk_q != nvm_pkg::ULK_IDLE) &&
	                    (i_seq_break || (32'(ulk_cnt_q) >= UNLOCK_GAP_CYC) ||
	                     (i_reg_wr && !wr_ulk && !go));
	assign op_end     = (st_q == nvm_pkg::ST_PROG) && (timer_q == '0);
	assign blank_lat  = op_end && (o_mem_op == nvm_pkg::OP_ROW);
	assign ind_go     = i_ind_rd && (st_q == nvm_pkg::ST_IDLE) && !go &&
	                    !(wr_ctrl && i_reg_wdata[nvm_pkg::B_RD]);

	// ----------------------------------------------------------------
	// unlock tracker
	// ----------------------------------------------------------------
	// steps must come in order and close together
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ulk_q     <= nvm_pkg::ULK_IDLE;
			ulk_cnt_q <= 4'h0;
		end else if (ulk_broken) begin
			ulk_q     <= nvm_pkg::ULK_IDLE;
			ulk_cnt_q <= 4'h0;
		end else if (wr_ulk) begin
			ulk_cnt_q <= 4'h0;
			if (i_reg_wdata == nvm_pkg::UNLOCK_A) begin
				ulk_q <= nvm_pkg::ULK_GOT_A;
			end else if (i_reg_wdata == nvm_pkg::UNLOCK_B && ulk_q == nvm_pkg::ULK_GOT_A) begin
				ulk_q <= nvm_pkg::ULK_ARMED;
			end else begin
				ulk_q <= nvm_pkg::ULK_IDLE;
			end
		end else if (go) begin
			ulk_q     <= nvm_pkg::ULK_IDLE;                 // sequence consumed
			ulk_cnt_q <= 4'h0;
		end else if (ulk_q != nvm_pkg::ULK_IDLE && ulk_cnt_q != 4'hf) begin
			ulk_cnt_q <= ulk_cnt_q + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// write error flag
	// ----------------------------------------------------------------
	// power-on clears; a later reset during a self-write leaves it set
	always_ff @(posedge i_clock) begin
		if (!i_por_n) begin
			werr_q <= 1'b0;
		end else if (!i_rst_n) begin
			werr_q <= werr_q | wr_q;
		end else if (reject || ulk_broken) begin
			werr_q <= 1'b1;
		end else if (wr_ctrl) begin
			werr_q <= i_reg_wdata[nvm_pkg::B_WERR];
		end
	end

	// ----------------------------------------------------------------
	// control bits
	// ----------------------------------------------------------------
	// mode bits are plain storage except free, which hw clears after an erase; start and read bits are set and hw cleared
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			regs_q <= 1'b0;
			latch_only_mode_q <= 1'b0;
			free_q <= 1'b0;
			write_enable_bit_q <= 1'b0;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
		end else begin
			if (wr_ctrl && st_q == nvm_pkg::ST_IDLE) begin
				regs_q <= i_reg_wdata[nvm_pkg::B_REGS];
				latch_only_mode_q <= i_reg_wdata[nvm_pkg::B_LATCH_ONLY_MODE];
				free_q <= i_reg_wdata[nvm_pkg::B_FREE];
				write_enable_bit_q <= i_reg_wdata[nvm_pkg::B_WRITE_ENABLE_BIT];
			end else if (op_end && o_mem_op == nvm_pkg::OP_ERASE) begin
				free_q <= 1'b0;
			end
			// start held only for array ops; refused or disabled ones never set
			if (go && i_reg_wdata[nvm_pkg::B_WRITE_ENABLE_BIT] && !reject && !lat_load) begin
				wr_q <= 1'b1;
			end else if (op_end) begin
				wr_q <= 1'b0;
			end
			if (wr_ctrl && i_reg_wdata[nvm_pkg::B_RD] && !go && st_q == nvm_pkg::ST_IDLE) begin
				rd_q <= 1'b1;
			end else if (st_q == nvm_pkg::ST_READ) begin
				rd_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// address and data registers
	// ----------------------------------------------------------------
	// read results overwrite data; otherwise software writes hold
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			adr_lo_q <= 8'h00;
			adr_hi_q <= 7'h00;
			dat_lo_q <= 8'h00;
			dat_hi_q <= 6'h00;
		end else begin
			if (i_reg_wr && i_reg_addr == nvm_pkg::OFF_ADR_LO && st_q == nvm_pkg::ST_IDLE) begin
				adr_lo_q <= i_reg_wdata;
			end
			if (i_reg_wr && i_reg_addr == nvm_pkg::OFF_ADR_HI && st_q == nvm_pkg::ST_IDLE) begin
				adr_hi_q <= i_reg_wdata[6:0];
			end
			if (st_q == nvm_pkg::ST_READ) begin
				if (full_adr[15:12] == nvm_pkg::DFM_SPACE) begin
					dat_lo_q <= dfm_hit ? i_mem_rdata[7:0] : 8'h00;
					dat_hi_q <= 6'h00;
				end else begin
					dat_lo_q <= i_mem_rdata[7:0];
					dat_hi_q <= i_mem_rdata[13:8];
				end
			end else begin
				if (i_reg_wr && i_reg_addr == nvm_pkg::OFF_DAT_LO) begin
					dat_lo_q <= i_reg_wdata;
				end
				if (i_reg_wr && i_reg_addr == nvm_pkg::OFF_DAT_HI) begin
					dat_hi_q <= i_reg_wdata[5:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// write latches
	// ----------------------------------------------------------------
	// one entry per word of the row; low five address bits pick it
	for (genvar gi = 0; gi < nvm_pkg::ROW_WORDS; gi++) begin : g_lat
		always_ff @(posedge i_clock) begin
			if (!i_rst_n || blank_lat) begin
				lat_q[gi] <= nvm_pkg::LATCH_BLANK;
			end else if (lat_load && adr_lo_q[nvm_pkg::LAT_W-1:0] == nvm_pkg::LAT_W'(gi)) begin
				lat_q[gi] <= {dat_hi_q, dat_lo_q};
			end
		end
	end

	// ----------------------------------------------------------------
	// operation sequencer
	// ----------------------------------------------------------------
	// drives the array and holds the cpu stalled while busy
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st_q         <= nvm_pkg::ST_IDLE;
			timer_q      <= '0;
			idx_q        <= '0;
			o_mem_addr   <= 16'h0000;
			o_mem_rd     <= 1'b0;
			o_mem_lat_we <= 1'b0;
			o_mem_wdata  <= 14'h0000;
			o_mem_start  <= 1'b0;
			o_mem_op     <= nvm_pkg::OP_NONE;
			o_cpu_stall  <= 1'b0;
		end else begin
			o_mem_rd     <= 1'b0;
			o_mem_lat_we <= 1'b0;
			o_mem_start  <= 1'b0;
			unique case (st_q)
				nvm_pkg::ST_IDLE: begin
					if (go && i_reg_wdata[nvm_pkg::B_WRITE_ENABLE_BIT] && !reject && !lat_load) begin
						o_mem_addr  <= {g_regs, adr_hi_q, adr_lo_q};
						o_cpu_stall <= 1'b1;
						if (g_dfm_space) begin
							o_mem_op    <= nvm_pkg::OP_DFM;
							o_mem_wdata <= {6'h00, dat_lo_q};
							o_mem_start <= 1'b1;
							timer_q     <= nvm_pkg::TIMER_W'(DFM_WRITE_CYC - 1);
							st_q        <= nvm_pkg::ST_PROG;
						end else if (i_reg_wdata[nvm_pkg::B_FREE]) begin
							o_mem_op    <= nvm_pkg::OP_ERASE;
							o_mem_start <= 1'b1;
							timer_q     <= nvm_pkg::TIMER_W'(PFM_ERASE_CYC - 1);
							st_q        <= nvm_pkg::ST_PROG;
						end else begin
							o_mem_op <= nvm_pkg::OP_ROW;
							idx_q    <= '0;
							st_q     <= nvm_pkg::ST_STREAM;
						end
					end else if (wr_ctrl && i_reg_wdata[nvm_pkg::B_RD] && !go) begin
						o_mem_addr  <= {i_reg_wdata[nvm_pkg::B_REGS], adr_hi_q, adr_lo_q};
						o_mem_rd    <= 1'b1;
						o_cpu_stall <= 1'b1;
						st_q        <= nvm_pkg::ST_READ;
					end else if (ind_go && i_ind_addr[15:12] == nvm_pkg::IND_DFM_TAG) begin
						// read-only path: only a read is ever issued
						o_mem_addr <= {1'b1, i_ind_addr[14:0]};
						o_mem_rd   <= 1'b1;
					end
				end
				nvm_pkg::ST_READ: begin
					o_cpu_stall <= 1'b0;
					st_q        <= nvm_pkg::ST_IDLE;
				end
				nvm_pkg::ST_STREAM: begin
					// hand each latch to the array; start programming with the last latch
					o_mem_addr   <= {o_mem_addr[15:nvm_pkg::LAT_W], idx_q};
					o_mem_wdata  <= lat_q[idx_q];
					o_mem_lat_we <= 1'b1;
					idx_q        <= idx_q + 1'b1;
					if (idx_q == nvm_pkg::LAT_W'(nvm_pkg::ROW_WORDS - 1)) begin
						o_mem_start <= 1'b1;
						timer_q     <= nvm_pkg::TIMER_W'(PFM_WRITE_CYC - 1);
						st_q        <= nvm_pkg::ST_PROG;
					end
				end
				nvm_pkg::ST_PROG: begin
					if (timer_q == '0) begin
						o_cpu_stall <= 1'b0;
						o_mem_op    <= nvm_pkg::OP_NONE;
						st_q        <= nvm_pkg::ST_IDLE;
					end else begin
						timer_q <= timer_q - 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// indirect read answer
	// ----------------------------------------------------------------
	// unimplemented or untagged addresses answer zero
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ind_pend_q  <= 1'b0;
			ind_dfm_q   <= 1'b0;
			o_ind_rdata <= 8'h00;
			o_ind_valid <= 1'b0;
		end else begin
			ind_pend_q  <= ind_go;
			ind_dfm_q   <= ind_go && (i_ind_addr[15:12] == nvm_pkg::IND_DFM_TAG) &&
			               ({4'h0, i_ind_addr[11:0]} < nvm_pkg::DFM_SIZE);
			o_ind_valid <= ind_pend_q;
			if (ind_pend_q) begin
				o_ind_rdata <= ind_dfm_q ? i_mem_rdata[7:0] : 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// completion status and interrupt
	// ----------------------------------------------------------------
	// completion sets the flag; set wins over a clearing write
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			done_q    <= 1'b0;
			ie_q      <= 1'b0;
			o_nvm_irq <= 1'b0;
		end else begin
			if (op_end) begin
				done_q <= 1'b1;
			end else if (i_reg_wr && i_reg_addr == nvm_pkg::OFF_STAT) begin
				done_q <= i_reg_wdata[nvm_pkg::B_DONE];
			end
			if (i_reg_wr && i_reg_addr == nvm_pkg::OFF_STAT) begin
				ie_q <= i_reg_wdata[nvm_pkg::B_IE];
			end
			o_nvm_irq <= done_q && ie_q;
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	// data one cycle after the strobe; unmapped reads answer zero
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				nvm_pkg::OFF_ADR_LO: o_reg_rdata <= adr_lo_q;
				nvm_pkg::OFF_ADR_HI: o_reg_rdata <= {1'b0, adr_hi_q};
				nvm_pkg::OFF_DAT_LO: o_reg_rdata <= dat_lo_q;
				nvm_pkg::OFF_DAT_HI: o_reg_rdata <= {2'b00, dat_hi_q};
				nvm_pkg::OFF_CTRL:   o_reg_rdata <= {1'b0, regs_q, latch_only_mode_q, free_q,
				                                     werr_q, write_enable_bit_q, wr_q, rd_q};
				nvm_pkg::OFF_STAT:   o_reg_rdata <= {6'h00, ie_q, done_q};
				default:             o_reg_rdata <= 8'h00;  // unlock reads zero
			endcase
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end
endmodule : nvm_self_write_controller

// File: dv/nvm_flash_model.sv
// flash array model facing the controller
`timescale 1ns/1ns
module nvm_flash_model (
	// array side of the controller
	input  wire logic        i_clock,
	input  wire logic [15:0] o_mem_addr,
	input  wire logic        o_mem_rd,
	input  wire logic        o_mem_lat_we,
	input  wire logic [13:0] o_mem_wdata,
	input  wire logic        o_mem_start,
	input  wire logic [1:0]  o_mem_op,
	output logic      [13:0] i_mem_rdata
);
	logic [13:0] m [logic [15:0]]; // sparse array
	logic [13:0] last_q = 14'h0;   // last word read
	// idle bus shows inverse of last word
	always_comb begin
		i_mem_rdata = ~last_q;
		if (o_mem_rd) i_mem_rdata = m.exists(o_mem_addr) ? m[o_mem_addr] : 14'h3fff;
	end
	// array updates
	always @(posedge i_clock) begin
		if (o_mem_rd) last_q <= i_mem_rdata;
		if (o_mem_lat_we) m[o_mem_addr] = o_mem_wdata;
		if (o_mem_start && o_mem_op == 2'h3) m[o_mem_addr] = o_mem_wdata;
		if (o_mem_start && o_mem_op == 2'h1)
			for (int k = 0; k < 32; k++) m[{o_mem_addr[15:5], k[4:0]}] = 14'h3fff;
	end
endmodule // nvm_flash_model

// File: dv/nvm_swc_chk.sv
// assertions on the controller ports
`timescale 1ns/1ns
module nvm_swc_chk (
	input wire logic        i_clock,
	input wire logic        i_rst_n,
	input wire logic [15:0] i_reg_addr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        i_reg_wr,
	input wire logic        i_ind_rd,
	input wire logic [15:0] i_ind_addr,
	input wire logic        i_data_flash_protect_cfg,
	input wire logic [14:0] i_pfm_wp_limit,
	input wire logic        o_cpu_stall,
	input wire logic        o_ind_valid,
	input wire logic [7:0]  o_ind_rdata,
	input wire logic        o_mem_rd,
	input wire logic [15:0] o_mem_addr,
	input wire logic        o_mem_lat_we,
	input wire logic        o_mem_start,
	input wire logic [1:0]  o_mem_op
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire ctl_wr = i_reg_wr && i_reg_addr == nvm_pkg::OFF_CTRL;
	wire aa_wr = i_reg_wr && i_reg_addr == nvm_pkg::OFF_UNLOCK && i_reg_wdata == 8'haa;
	logic [3:0] aa_age_q; // cycles since second unlock byte
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) aa_age_q <= 4'hf;
		else if (aa_wr) aa_age_q <= 4'h0;
		else if (aa_age_q != 4'hf) aa_age_q <= aa_age_q + 4'h1;
	end
	rd_stall_a: assert property (ctl_wr && i_reg_wdata[1:0] == 2'h1 && !o_cpu_stall
		|=> o_mem_rd && o_cpu_stall ##1 !o_cpu_stall) else $error("read stall wrong");
	ind_valid_a: assert property (i_ind_rd && !o_cpu_stall && !o_mem_rd |-> ##2 o_ind_valid)
		else $error("indirect read not answered");
	ind_zero_a: assert property (o_ind_valid && $past(i_ind_addr[15:12], 2) != 4'h7
		|-> o_ind_rdata == 8'h00) else $error("indirect miss not zero");
	dfm_prot_a: assert property (o_mem_start && o_mem_op == 2'h3 |-> i_data_flash_protect_cfg)
		else $error("protected data flash written");
	pfm_wp_a: assert property (o_mem_start && o_mem_op != 2'h3 && !o_mem_addr[15]
		|-> o_mem_addr[14:0] >= i_pfm_wp_limit) else $error("protected row touched");
	op_stall_a: assert property (o_mem_start && o_mem_op != 2'h2 |-> o_cpu_stall)
		else $error("cpu runs during operation");
	lat_seq_a: assert property (o_mem_lat_we && o_mem_addr[4:0] != 5'h1f |=> o_mem_lat_we
		&& o_mem_addr[4:0] == $past(o_mem_addr[4:0]) + 5'h1) else $error("latch order");
	unlock_ok_a: assert property (o_mem_start && o_mem_op != 2'h2 |-> aa_age_q <= 4'h5)
		else $error("operation without unlock");
	cover property (o_mem_start && o_mem_op == 2'h3);
	cover property (o_ind_valid);
	cover property (o_mem_lat_we && o_mem_addr[4:0] == 5'h1f);
endmodule // nvm_swc_chk
bind nvm_self_write_controller nvm_swc_chk i_chk (.*);

// File: dv/test_nvm_self_write_controller.sv
// self-checking bench for the nvm self-write controller
`timescale 1ns/1ns
module test_nvm_self_write_controller;
	localparam logic [15:0] AL = nvm_pkg::OFF_ADR_LO, AH = nvm_pkg::OFF_ADR_HI, DL = nvm_pkg::OFF_DAT_LO;
	localparam logic [15:0] DH = nvm_pkg::OFF_DAT_HI, CT = nvm_pkg::OFF_CTRL, UL = nvm_pkg::OFF_UNLOCK;
	logic i_clock, i_rst_n, i_por_n, i_reg_wr, i_reg_rd, i_seq_break, i_ind_rd, o_cpu_stall;
	logic i_data_flash_protect_cfg, o_nvm_irq, o_ind_valid, o_mem_rd, o_mem_lat_we, o_mem_start;
	logic [15:0] i_reg_addr, i_ind_addr, o_mem_addr;
	logic [7:0]  i_reg_wdata, o_reg_rdata, o_ind_rdata;
	logic [14:0] i_pfm_wp_limit;
	logic [13:0] i_mem_rdata, o_mem_wdata;
	logic [1:0]  o_mem_op;
	int          error_cnt = 0, comparisons = 0;
	nvm_self_write_controller #(.PFM_ERASE_CYC(8), .PFM_WRITE_CYC(12), .DFM_WRITE_CYC(10))
		i_nvm_self_write_controller (.i_clock, .i_rst_n, .i_por_n, .i_reg_addr, .i_reg_wdata,
		.i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_seq_break, .o_cpu_stall, .o_nvm_irq, .i_ind_rd,
		.i_ind_addr, .o_ind_rdata, .o_ind_valid, .i_pfm_wp_limit, .i_data_flash_protect_cfg,
		.o_mem_addr, .o_mem_rd, .i_mem_rdata, .o_mem_lat_we, .o_mem_wdata, .o_mem_start,
		.o_mem_op);
	nvm_flash_model i_nvm_flash_model (.i_clock, .o_mem_addr, .o_mem_rd, .o_mem_lat_we,
		.o_mem_wdata, .o_mem_start, .o_mem_op, .i_mem_rdata);
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
		#1 chk({8'h0, o_reg_rdata}, {8'h0, exp});
	endtask
	task automatic ind(input logic [15:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_ind_rd <= 1'b1;
		i_ind_addr <= a;
		@(posedge i_clock);
		i_ind_rd <= 1'b0;
		@(posedge i_clock);
		#1 chk({7'h0, o_ind_valid, o_ind_rdata}, {8'h1, exp});
	endtask
	task automatic ulk(input logic [7:0] c);
		wr(UL, 8'h55);
		wr(UL, 8'haa);
		wr(CT, c);
	endtask
	task automatic t_dfm;
		wr(AH, 8'h70);
		wr(AL, 8'h03);
		wr(DL, 8'h5a);
		wr(CT, 8'h44);
		wr(nvm_pkg::OFF_STAT, 8'h02);
		ulk(8'h46);
		repeat (20) @(posedge i_clock);
		rd(CT, 8'h44);
		rd(nvm_pkg::OFF_STAT, 8'h03);
		chk({15'h0, o_nvm_irq}, 16'h1);
		chk(i_nvm_flash_model.m[16'hf003], 16'h005a);
		wr(DL, 8'h00);
		wr(CT, 8'h41);
		repeat (3) @(posedge i_clock);
		rd(DL, 8'h5a);
		ind(16'h7003, 8'h5a);
		ind(16'h3003, 8'h00);
		wr(DL, 8'hff);
		ulk(8'h46);
		repeat (20) @(posedge i_clock);
		chk(i_nvm_flash_model.m[16'hf003], 16'h00ff);
		wr(nvm_pkg::OFF_STAT, 8'h00);
	endtask
	task automatic t_err;
		wr(UL, 8'h55);
		wr(AL, 8'h03);
		rd(CT, 8'h4c);
		wr(CT, 8'h44);
		rd(CT, 8'h44);
		wr(CT, 8'h4c);
		rd(CT, 8'h4c);
		wr(UL, 8'h55);
		wr(UL, 8'h12);
		wr(CT, 8'h46);
		rd(CT, 8'h44);
		wr(UL, 8'h55);
		i_seq_break <= 1'b1;
		@(posedge i_clock);
		i_seq_break <= 1'b0;
		rd(CT, 8'h4c);
	endtask
	task automatic t_prot;
		i_data_flash_protect_cfg <= 1'b0;
		ulk(8'h46);
		rd(CT, 8'h4c);
		i_data_flash_protect_cfg <= 1'b1;
		ulk(8'h46);
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd(CT, 8'h08);
	endtask
	task automatic t_pfm;
		wr(AH, 8'h02);
		wr(AL, 8'h03);
		wr(DH, 8'h12);
		wr(DL, 8'h34);
		ulk(8'h26);
		ulk(8'h06);
		repeat (60) @(posedge i_clock);
		chk(i_nvm_flash_model.m[16'h0203], 16'h1234);
		chk(i_nvm_flash_model.m[16'h0200], 16'h3fff);
		ulk(8'h16);
		repeat (20) @(posedge i_clock);
		chk(i_nvm_flash_model.m[16'h0203], 16'h3fff);
		wr(AH, 8'h00);
		ulk(8'h16);
		rd(CT, 8'h1c);
	endtask
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{i_rst_n, i_por_n, i_reg_wr, i_reg_rd, i_seq_break, i_ind_rd} = 6'h0;
		{i_reg_addr, i_reg_wdata, i_ind_addr} = 40'h0;
		i_pfm_wp_limit = 15'h0100;
		i_data_flash_protect_cfg = 1'b1;
		repeat (5) @(posedge i_clock);
		i_rst_n <= 1'b1;
		i_por_n <= 1'b1;
		t_dfm;
		t_err;
		t_prot;
		t_pfm;
		give_verdict;
	end
	initial begin
		#300000;
		error_cnt++;
		give_verdict;
	end
endmodule // test_nvm_self_write_controller
